// file: hdl/wide_timer_byte_access_counter.sv
`timescale 1ns/10ps
`default_nettype none
`include "wide_timer_defs.svh"

module wide_timer_byte_access_counter
  import wide_timer_pkg::*;
  (
    input  wire logic                 ref_clk,
    input  wire logic                 resetn,
    input  wire logic                 clkEn,
    input  wire logic [`IO_ADDR_W-1:0] ioAddr,
    input  wire logic                 ioWrEn,
    input  wire logic                 ioRdEn,
    input  wire logic [7:0]           ioWrData,
    output logic      [7:0]           ioRdData,
    input  wire logic                 extClockPin,
    input  wire logic                 captureEvent,
    output logic                      overflowFlag,
    output logic                      countFloorHit,
    output logic                      countCeilingHit
  );

  function automatic count_kind_t kindOf(input wave_mode_t m);
    unique case (m)
      4'h0, 4'hd:             kindOf = KIND_NORMAL;
      4'h4, 4'hc:             kindOf = KIND_CTC;
      4'h5, 4'h6, 4'h7,
      4'he, 4'hf:             kindOf = KIND_FAST;
      4'h1, 4'h2, 4'h3, 4'h8,
      4'h9, 4'ha, 4'hb:       kindOf = KIND_PHASE;
    endcase
  endfunction : kindOf

  function automatic word_t topOf(input wave_mode_t m, input word_t cmpA,
                                  input word_t cap);
    unique case (m)
      4'h1, 4'h5:             topOf = `TOP_8BIT;
      4'h2, 4'h6:             topOf = `TOP_9BIT;
      4'h3, 4'h7:             topOf = `TOP_10BIT;
      4'h4, 4'h9, 4'hb, 4'hf: topOf = cmpA;
      4'h8, 4'ha, 4'hc, 4'he: topOf = cap;
      4'h0, 4'hd:             topOf = `COUNT_MAX;
    endcase
  endfunction : topOf

  function automatic logic capIsTop(input wave_mode_t m);
    capIsTop = (m == 4'h8) || (m == 4'ha) || (m == 4'hc) || (m == 4'he);
  endfunction : capIsTop

  byte_t       ctrlA_r;
  byte_t       ctrlB_r;
  byte_t       hold_r;
  word_t       count_r;
  word_t       count_nxt;
  logic        dirDown_r;
  logic        dirDown_nxt;
  word_t       cmpA_r;
  word_t       cmpB_r;
  word_t       cap_r;
  logic        overflow_r;
  logic        ovfSet;
  byte_t       rdData_r;
  byte_t       rdData_nxt;
  logic        floorHit_r;
  logic        ceilingHit_r;
  wave_mode_t  waveMode;
  count_kind_t countKind;
  word_t       topNow;
  logic        timerTick;
  logic        wrCntLo;
  logic        wrCmpALo;
  logic        wrCmpBLo;
  logic        wrCapLo;
  logic        wrAnyHi;
  logic        rdCntLo;
  logic        rdCapLo;

  assign waveMode  = {ctrlB_r[`CTLB_MODE_HI], ctrlA_r[`CTLA_MODE_LO]};
  assign countKind = kindOf(waveMode);
  assign topNow    = topOf(waveMode, cmpA_r, cap_r);

  // access decode, only low byte locations trigger wide transfers
  assign wrCntLo  = ioWrEn && (ioAddr == `OFS_COUNT_LO);
  assign wrCmpALo = ioWrEn && (ioAddr == `OFS_CMPA_LO);
  assign wrCmpBLo = ioWrEn && (ioAddr == `OFS_CMPB_LO);
  assign wrCapLo  = ioWrEn && (ioAddr == `OFS_CAP_LO) && capIsTop(waveMode);
  assign wrAnyHi  = ioWrEn && ((ioAddr == `OFS_COUNT_HI) || (ioAddr == `OFS_CMPA_HI) ||
                               (ioAddr == `OFS_CMPB_HI) || (ioAddr == `OFS_CAP_HI));
  assign rdCntLo  = ioRdEn && !ioWrEn && (ioAddr == `OFS_COUNT_LO);
  assign rdCapLo  = ioRdEn && !ioWrEn && (ioAddr == `OFS_CAP_LO);

  timer_tick_select #(.PRESCALE_W(`PRESCALE_BITS)) timer_tick_select_inst (
    .ref_clk           (ref_clk),
    .resetn            (resetn),
    .clkEn             (clkEn),
    .clockSourceSelect (ctrlB_r[`CTLB_CS]),
    .extClockPin       (extClockPin),
    .timerTick         (timerTick)
  );

  // control registers
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctrlA_r <= `RST_BYTE;
      ctrlB_r <= `RST_BYTE;
    end else if (clkEn && ioWrEn) begin
      if (ioAddr == `OFS_CTRL_A) begin
        ctrlA_r <= ioWrData;
      end
      if (ioAddr == `OFS_CTRL_B) begin
        ctrlB_r <= ioWrData;
      end
    end
  end

  // shared high byte holding register; a write wins over a read
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      hold_r <= `RST_BYTE;
    end else if (clkEn) begin
      if (wrAnyHi) begin
        hold_r <= ioWrData;
      end else if (rdCntLo) begin
        hold_r <= count_r[15:8];
      end else if (rdCapLo) begin
        hold_r <= cap_r[15:8];
      end
    end
  end

  // counter next value
  always_comb begin
    count_nxt   = count_r;
    dirDown_nxt = (countKind == KIND_PHASE) ? dirDown_r : 1'b0;
    ovfSet      = 1'b0;
    if (wrCntLo) begin
      count_nxt = {hold_r, ioWrData};
    end else if (timerTick) begin
      unique case (countKind)
        KIND_NORMAL: begin
          count_nxt = count_r + 16'h0001;
          ovfSet    = (count_r == `COUNT_MAX);
        end
        KIND_CTC: begin
          count_nxt = (count_r == topNow) ? `COUNT_FLOOR : count_r + 16'h0001;
          ovfSet    = (count_r == `COUNT_MAX);
        end
        KIND_FAST: begin
          if (count_r >= topNow) begin
            count_nxt = `COUNT_FLOOR;
            ovfSet    = 1'b1;
          end else begin
            count_nxt = count_r + 16'h0001;
          end
        end
        KIND_PHASE: begin
          if (dirDown_r) begin
            if (count_r == `COUNT_FLOOR) begin
              dirDown_nxt = 1'b0;
              count_nxt   = count_r + 16'h0001;
              ovfSet      = 1'b1;
            end else begin
              count_nxt = count_r - 16'h0001;
            end
          end else if (count_r >= topNow) begin
            dirDown_nxt = 1'b1;
            count_nxt   = count_r - 16'h0001;
          end else begin
            count_nxt = count_r + 16'h0001;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      count_r   <= `RST_WORD;
      dirDown_r <= 1'b0;
    end else if (clkEn) begin
      count_r   <= count_nxt;
      dirDown_r <= dirDown_nxt;
    end
  end

  // floor and ceiling indications track the counter
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      floorHit_r   <= 1'b1;
      ceilingHit_r <= 1'b0;
    end else if (clkEn) begin
      floorHit_r   <= (count_nxt == `COUNT_FLOOR);
      ceilingHit_r <= (count_nxt == topNow);
    end
  end

  // compare values
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cmpA_r <= `RST_WORD;
      cmpB_r <= `RST_WORD;
    end else if (clkEn) begin
      if (wrCmpALo) begin
        cmpA_r <= {hold_r, ioWrData};
      end
      if (wrCmpBLo) begin
        cmpB_r <= {hold_r, ioWrData};
      end
    end
  end

  // capture value: written only when it sets top, else loaded by events
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cap_r <= `RST_WORD;
    end else if (clkEn) begin
      if (wrCapLo) begin
        cap_r <= {hold_r, ioWrData};
      end else if (captureEvent && !capIsTop(waveMode)) begin
        cap_r <= count_r;
      end
    end
  end

  // overflow flag: hardware set beats write-one clear
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      overflow_r <= 1'b0;
    end else if (clkEn) begin
      if (ovfSet) begin
        overflow_r <= 1'b1;
      end else if (ioWrEn && (ioAddr == `OFS_FLAGS) && ioWrData[`FLAG_OVF]) begin
        overflow_r <= 1'b0;
      end
    end
  end

  // read mux
  always_comb begin
    rdData_nxt = `RST_BYTE;
    if (ioRdEn && !ioWrEn) begin
      unique case (ioAddr)
        `OFS_CTRL_A:   rdData_nxt = ctrlA_r;
        `OFS_CTRL_B:   rdData_nxt = ctrlB_r;
        `OFS_FLAGS:    rdData_nxt = {7'h00, overflow_r};
        `OFS_COUNT_LO: rdData_nxt = count_r[7:0];
        `OFS_COUNT_HI: rdData_nxt = hold_r;
        `OFS_CMPA_LO:  rdData_nxt = cmpA_r[7:0];
        `OFS_CMPA_HI:  rdData_nxt = cmpA_r[15:8];
        `OFS_CMPB_LO:  rdData_nxt = cmpB_r[7:0];
        `OFS_CMPB_HI:  rdData_nxt = cmpB_r[15:8];
        `OFS_CAP_LO:   rdData_nxt = cap_r[7:0];
        `OFS_CAP_HI:   rdData_nxt = hold_r;
        default:       rdData_nxt = `RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rdData_r <= `RST_BYTE;
    end else if (clkEn) begin
      rdData_r <= rdData_nxt;
    end
  end

  assign ioRdData        = rdData_r;
  assign overflowFlag    = overflow_r;
  assign countFloorHit   = floorHit_r;
  assign countCeilingHit = ceilingHit_r;

  AST_LOW_WRITE_LOADS: assert property (@(posedge ref_clk) disable iff (!resetn)
    clkEn && wrCntLo |=> count_r == {$past(hold_r), $past(ioWrData)})
    else $error("count low write did not load holding and data bytes");

  AST_LOW_READ_COPIES: assert property (@(posedge ref_clk) disable iff (!resetn)
    clkEn && rdCntLo |=> hold_r == $past(count_r[15:8]) && ioRdData == $past(count_r[7:0]))
    else $error("count low read did not copy upper byte");

  AST_HIGH_WRITE_HOLDS: assert property (@(posedge ref_clk) disable iff (!resetn)
    clkEn && wrAnyHi |=> hold_r == $past(ioWrData))
    else $error("high byte write did not reach holding byte");

  AST_HIGH_ALONE_INERT: assert property (@(posedge ref_clk) disable iff (!resetn)
    clkEn && wrAnyHi && !timerTick |=> $stable(count_r) && $stable(cmpA_r) && $stable(cmpB_r))
    else $error("high byte write moved a wide register");

  AST_COMPARE_READ_DIRECT: assert property (@(posedge ref_clk) disable iff (!resetn)
    clkEn && ioRdEn && !ioWrEn && ioAddr == `OFS_CMPB_HI
    |=> ioRdData == $past(cmpB_r[15:8]) && $stable(hold_r))
    else $error("compare high read wrong or disturbed holding byte");

  AST_STOPPED: assert property (@(posedge ref_clk) disable iff (!resetn)
    ctrlB_r[`CTLB_CS] == `CS_STOP && !wrCntLo |-> !timerTick ##1 $stable(count_r))
    else $error("counter moved with no clock source");

  AST_STEP_ONE: assert property (@(posedge ref_clk) disable iff (!resetn)
    clkEn && timerTick && !wrCntLo
    |=> count_r == 16'($past(count_r) + 16'h0001) || count_r == 16'($past(count_r) - 16'h0001)
        || count_r == `COUNT_FLOOR)
    else $error("counter changed by other than one");

  AST_FLOOR_TRACKS: assert property (@(posedge ref_clk) disable iff (!resetn)
    countFloorHit == (count_r == `COUNT_FLOOR))
    else $error("floor indication disagrees with counter");

  AST_OVF_NORMAL: assert property (@(posedge ref_clk) disable iff (!resetn)
    clkEn && timerTick && !wrCntLo && waveMode == 4'h0 && count_r == `COUNT_MAX
    |=> overflowFlag && count_r == `COUNT_FLOOR)
    else $error("normal mode wrap did not set overflow");

endmodule : wide_timer_byte_access_counter
`default_nettype wire

// file: shared/wide_timer_defs.svh
`ifndef WIDE_TIMER_DEFS_SVH
`define WIDE_TIMER_DEFS_SVH

// processor i/o location offsets
`define IO_ADDR_W       4
`define OFS_CTRL_A      4'h0
`define OFS_CTRL_B      4'h1
`define OFS_FLAGS       4'h2
`define OFS_COUNT_LO    4'h4
`define OFS_COUNT_HI    4'h5
`define OFS_CMPA_LO     4'h6
`define OFS_CMPA_HI     4'h7
`define OFS_CMPB_LO     4'h8
`define OFS_CMPB_HI     4'h9
`define OFS_CAP_LO      4'ha
`define OFS_CAP_HI      4'hb

// field positions
`define CTLA_MODE_LO    1:0
`define CTLB_CS         2:0
`define CTLB_MODE_HI    4:3
`define FLAG_OVF        0

// reset values
`define RST_BYTE        8'h00
`define RST_WORD        16'h0000

// counter limits
`define COUNT_FLOOR     16'h0000
`define COUNT_MAX       16'hffff
`define TOP_8BIT        16'h00ff
`define TOP_9BIT        16'h01ff
`define TOP_10BIT       16'h03ff

// clock source select codes
`define CS_STOP         3'h0
`define CS_DIV1         3'h1
`define CS_DIV8         3'h2
`define CS_DIV64        3'h3
`define CS_DIV256       3'h4
`define CS_DIV1024      3'h5
`define CS_EXT_FALL     3'h6
`define CS_EXT_RISE     3'h7

`define PRESCALE_BITS   10

`endif

// file: shared/wide_timer_pkg.sv
`default_nettype none
package wide_timer_pkg;

  typedef logic [7:0]  byte_t;
  typedef logic [15:0] word_t;
  typedef logic [3:0]  wave_mode_t;

  typedef enum logic [1:0] {
    KIND_NORMAL,
    KIND_CTC,
    KIND_FAST,
    KIND_PHASE
  } count_kind_t;

endpackage : wide_timer_pkg
`default_nettype wire

// file: hdl/timer_tick_select.sv
`timescale 1ns/10ps
`default_nettype none
`include "wide_timer_defs.svh"

module timer_tick_select
  #(parameter int unsigned PRESCALE_W = `PRESCALE_BITS)
  (
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    input  wire logic       clkEn,
    input  wire logic [2:0] clockSourceSelect,
    input  wire logic       extClockPin,
    output logic            timerTick
  );

  logic [PRESCALE_W-1:0] prescale_r;
  logic                  extSync1_r;
  logic                  extSync2_r;
  logic                  extSync3_r;
  logic                  extLevel_r;
  logic                  extAgree;
  logic                  extRise;
  logic                  extFall;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      prescale_r <= '0;
    end else if (clkEn) begin
      prescale_r <= prescale_r + 1'b1;
    end
  end

  // pin passes three stages; a level counts once stages two and three agree
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      extSync1_r <= 1'b0;
      extSync2_r <= 1'b0;
      extSync3_r <= 1'b0;
      extLevel_r <= 1'b0;
    end else if (clkEn) begin
      extSync1_r <= extClockPin;
      extSync2_r <= extSync1_r;
      extSync3_r <= extSync2_r;
      if (extAgree) begin
        extLevel_r <= extSync3_r;
      end
    end
  end

  assign extAgree = (extSync2_r == extSync3_r);
  assign extRise  = extAgree && extSync3_r && !extLevel_r;
  assign extFall  = extAgree && !extSync3_r && extLevel_r;

  always_comb begin
    unique case (clockSourceSelect)
      `CS_STOP:     timerTick = 1'b0;
      `CS_DIV1:     timerTick = clkEn;
      `CS_DIV8:     timerTick = clkEn && (&prescale_r[2:0]);
      `CS_DIV64:    timerTick = clkEn && (&prescale_r[5:0]);
      `CS_DIV256:   timerTick = clkEn && (&prescale_r[7:0]);
      `CS_DIV1024:  timerTick = clkEn && (&prescale_r[9:0]);
      `CS_EXT_FALL: timerTick = clkEn && extFall;
      `CS_EXT_RISE: timerTick = clkEn && extRise;
    endcase
  end

endmodule : timer_tick_select
`default_nettype wire

// file: bench/cpu_bus_model.sv
`timescale 1ns/10ps
`default_nettype none
`include "wide_timer_defs.svh"

module cpu_bus_model
  import wide_timer_pkg::*;
  (
    input  wire logic                  ref_clk,
    output logic [`IO_ADDR_W-1:0]      ioAddr,
    output logic                       ioWrEn,
    output logic                       ioRdEn,
    output logic [7:0]                 ioWrData
  );
  byte_t expQ[$];

  initial begin
    ioAddr   = '0;
    ioWrEn   = 1'b0;
    ioRdEn   = 1'b0;
    ioWrData = 8'h00;
  end

  // one access at a time, never interleaved with another master
  task automatic wr(input logic [`IO_ADDR_W-1:0] a, input byte_t d);
    @(negedge ref_clk);
    ioAddr   = a;
    ioWrData = d;
    ioWrEn   = 1'b1;
    @(negedge ref_clk);
    ioWrEn   = 1'b0;
    ioWrData = ~d;
  endtask : wr

  task automatic rd(input logic [`IO_ADDR_W-1:0] a, input byte_t e);
    @(negedge ref_clk);
    expQ.push_back(e);
    ioAddr = a;
    ioRdEn = 1'b1;
    @(negedge ref_clk);
    ioRdEn = 1'b0;
    ioAddr = ~a;
  endtask : rd

  task automatic wide_wr(input logic [`IO_ADDR_W-1:0] lo, input word_t v);
    wr(lo + 4'h1, v[15:8]);
    wr(lo, v[7:0]);
  endtask : wide_wr

  task automatic wide_rd(input logic [`IO_ADDR_W-1:0] lo, input word_t v);
    rd(lo, v[7:0]);
    rd(lo + 4'h1, v[15:8]);
  endtask : wide_rd
endmodule : cpu_bus_model
`default_nettype wire

// file: bench/wide_timer_byte_access_counter_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "wide_timer_defs.svh"

module wide_timer_byte_access_counter_tb
  import wide_timer_pkg::*;
  ;
  logic                  ref_clk;
  logic                  resetn;
  logic                  clkEn;
  logic                  extClockPin;
  logic                  captureEvent;
  logic [`IO_ADDR_W-1:0] ioAddr;
  logic                  ioWrEn;
  logic                  ioRdEn;
  logic [7:0]            ioWrData;
  logic [7:0]            ioRdData;
  logic                  overflowFlag;
  logic                  countFloorHit;
  logic                  countCeilingHit;
  logic                  rdSeen;
  logic [15:0]           lfsrState;
  int                    num_errors;
  int                    total_checks;

  cpu_bus_model cpu_bus_model_inst (
    .ref_clk(ref_clk), .ioAddr(ioAddr), .ioWrEn(ioWrEn), .ioRdEn(ioRdEn), .ioWrData(ioWrData)
  );

  wide_timer_byte_access_counter wide_timer_byte_access_counter_inst (
    .ref_clk(ref_clk), .resetn(resetn), .clkEn(clkEn), .ioAddr(ioAddr), .ioWrEn(ioWrEn),
    .ioRdEn(ioRdEn), .ioWrData(ioWrData), .ioRdData(ioRdData), .extClockPin(extClockPin),
    .captureEvent(captureEvent), .overflowFlag(overflowFlag),
    .countFloorHit(countFloorHit), .countCeilingHit(countCeilingHit)
  );

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr

  task automatic close_out();
    if (num_errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out

  task automatic chk(input byte_t seen, input byte_t exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic pick(input int which);
    case (which)
      0:       return countCeilingHit;
      1:       return countFloorHit;
      default: return overflowFlag;
    endcase
  endfunction : pick

  // bounded wait for a status output to go high
  task automatic wait_high(input int which);
    int n;
    n = 0;
    while (pick(which) !== 1'b1) begin
      if (n == 300) begin
        num_errors++;
        close_out();
      end
      n++;
      @(negedge ref_clk);
    end
  endtask : wait_high

  // read data stands the cycle after the strobe edge
  always @(posedge ref_clk) begin
    rdSeen <= resetn & ioRdEn & ~ioWrEn;
  end

  always @(negedge ref_clk) begin
    if (rdSeen === 1'b1) begin
      chk(ioRdData, cpu_bus_model_inst.expQ.pop_front());
    end
  end

  initial begin
    #(5 * 40000);
    num_errors++;
    close_out();
  end

  initial begin
    resetn       = 1'b0;
    clkEn        = 1'b1;
    extClockPin  = 1'b0;
    captureEvent = 1'b0;
    num_errors   = 0;
    total_checks = 0;
    lfsrState    = 16'h7a9e;
    repeat (16) @(negedge ref_clk);
    resetn = 1'b1;
    chk({7'h00, countFloorHit}, 8'h01);
    chk({7'h00, overflowFlag}, 8'h00);
    cpu_bus_model_inst.wide_rd(`OFS_COUNT_LO, `RST_WORD);
    cpu_bus_model_inst.rd(`OFS_CTRL_B, `RST_BYTE);
    cpu_bus_model_inst.rd(4'h3, 8'h00);
    cpu_bus_model_inst.wide_wr(`OFS_COUNT_LO, 16'h01ff);
    cpu_bus_model_inst.wide_rd(`OFS_COUNT_LO, 16'h01ff);
    cpu_bus_model_inst.wr(`OFS_COUNT_HI, 8'h55);
    cpu_bus_model_inst.wide_rd(`OFS_COUNT_LO, 16'h01ff);
    // one high byte serves two compare writes
    cpu_bus_model_inst.wr(`OFS_COUNT_HI, 8'hab);
    cpu_bus_model_inst.wr(`OFS_CMPA_LO, 8'h12);
    cpu_bus_model_inst.wr(`OFS_CMPB_LO, 8'h34);
    cpu_bus_model_inst.rd(`OFS_COUNT_LO, 8'hff);
    cpu_bus_model_inst.rd(`OFS_CMPA_HI, 8'hab);
    cpu_bus_model_inst.rd(`OFS_CMPB_HI, 8'hab);
    cpu_bus_model_inst.rd(`OFS_COUNT_HI, 8'h01);
    for (int i = 0; i < 6; i++) begin
      lfsrState = lfsr(lfsrState);
      cpu_bus_model_inst.wide_wr(`OFS_COUNT_LO, lfsrState);
      cpu_bus_model_inst.wide_rd(`OFS_COUNT_LO, lfsrState);
      lfsrState = lfsr(lfsrState);
      cpu_bus_model_inst.wide_wr(`OFS_CMPB_LO, lfsrState);
      cpu_bus_model_inst.wide_rd(`OFS_CMPB_LO, lfsrState);
    end
    // running counter: write must win and wrap must follow within bound
    cpu_bus_model_inst.wide_wr(`OFS_COUNT_LO, 16'h0000);
    cpu_bus_model_inst.wr(`OFS_CTRL_B, {5'h00, `CS_DIV1});
    cpu_bus_model_inst.wide_wr(`OFS_COUNT_LO, 16'hfff0);
    wait_high(0);
    @(negedge ref_clk);
    chk({7'h00, countFloorHit}, 8'h01);
    chk({7'h00, countCeilingHit}, 8'h00);
    wait_high(2);
    cpu_bus_model_inst.rd(`OFS_FLAGS, 8'h01);
    cpu_bus_model_inst.wr(`OFS_FLAGS, 8'h01);
    chk({7'h00, overflowFlag}, 8'h00);
    cpu_bus_model_inst.wr(`OFS_CTRL_B, {5'h00, `CS_STOP});
    cpu_bus_model_inst.wide_wr(`OFS_COUNT_LO, 16'h1234);
    repeat (20) @(negedge ref_clk);
    cpu_bus_model_inst.wide_rd(`OFS_COUNT_LO, 16'h1234);
    // capture event loads the stopped count; low read fills the holding byte
    @(negedge ref_clk);
    captureEvent = 1'b1;
    @(negedge ref_clk);
    captureEvent = 1'b0;
    cpu_bus_model_inst.wide_rd(`OFS_CAP_LO, 16'h1234);
    // clear-on-compare mode with top 3
    cpu_bus_model_inst.wide_wr(`OFS_CMPA_LO, 16'h0003);
    cpu_bus_model_inst.wide_wr(`OFS_COUNT_LO, 16'h0000);
    cpu_bus_model_inst.wr(`OFS_CTRL_B, 8'h09);
    cpu_bus_model_inst.rd(`OFS_CTRL_B, 8'h09);
    wait_high(0);
    @(negedge ref_clk);
    chk({7'h00, countFloorHit}, 8'h01);
    chk({7'h00, overflowFlag}, 8'h00);
    for (int k = 6; k < 8; k++) begin
      cpu_bus_model_inst.wr(`OFS_CTRL_B, {5'h00, `CS_STOP});
      cpu_bus_model_inst.wide_wr(`OFS_COUNT_LO, 16'h0000);
      cpu_bus_model_inst.wr(`OFS_CTRL_B, 8'(k));
      repeat (3) begin
        repeat (8) @(negedge ref_clk);
        extClockPin = 1'b1;
        repeat (8) @(negedge ref_clk);
        extClockPin = 1'b0;
      end
      repeat (8) @(negedge ref_clk);
      cpu_bus_model_inst.wr(`OFS_CTRL_B, {5'h00, `CS_STOP});
      cpu_bus_model_inst.wide_rd(`OFS_COUNT_LO, 16'h0003);
    end
    // fast 8-bit mode on the divide-by-8 tick: wrap past 0xff sets overflow
    cpu_bus_model_inst.wide_wr(`OFS_COUNT_LO, 16'h00f0);
    cpu_bus_model_inst.wr(`OFS_CTRL_A, 8'h01);
    cpu_bus_model_inst.rd(`OFS_FLAGS, 8'h00);
    cpu_bus_model_inst.wr(`OFS_CTRL_B, {5'h01, `CS_DIV8});
    wait_high(2);
    chk({7'h00, countFloorHit}, 8'h01);
    chk({7'h00, countCeilingHit}, 8'h00);
    cpu_bus_model_inst.wr(`OFS_FLAGS, 8'h01);
    // phase 8-bit mode every cycle: turns at 0xff, overflow on leaving zero
    cpu_bus_model_inst.wr(`OFS_CTRL_B, {5'h00, `CS_STOP});
    cpu_bus_model_inst.wide_wr(`OFS_COUNT_LO, 16'h00fc);
    cpu_bus_model_inst.wr(`OFS_CTRL_B, {5'h00, `CS_DIV1});
    wait_high(2);
    cpu_bus_model_inst.wr(`OFS_CTRL_B, {5'h00, `CS_STOP});
    cpu_bus_model_inst.wide_rd(`OFS_COUNT_LO, 16'h0003);
    // clock enable low: accesses are not taken and the count holds
    clkEn = 1'b0;
    cpu_bus_model_inst.wr(`OFS_CTRL_B, {5'h00, `CS_DIV1});
    cpu_bus_model_inst.wr(`OFS_COUNT_LO, 8'hee);
    clkEn = 1'b1;
    cpu_bus_model_inst.wide_rd(`OFS_COUNT_LO, 16'h0003);
    cpu_bus_model_inst.rd(`OFS_CTRL_B, 8'h00);
    repeat (4) @(negedge ref_clk);
    close_out();
  end
endmodule : wide_timer_byte_access_counter_tb
`default_nettype wire
